// file: rtl/osm_half_delay.sv
// Half dot period delay line for the blanking output.
`default_nettype none
module osm_half_delay #(
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // Data.
   input  wire logic       din,
   input  wire logic [3:0] code,
   output logic            dout
);
   typedef struct packed {
      logic [DEPTH-1:0] tap;
      logic             out;
   } osm_dly_s;

   osm_dly_s state_q;
   osm_dly_s state_d;

   // The block clock runs at twice the dot rate, so each tap is half a dot.
   always_comb begin
      state_d     = state_q;
      state_d.tap = {state_q.tap[DEPTH-2:0], din};
      if (code == 4'h0) begin
         state_d.out = din;
      end else begin
         state_d.out = state_q.tap[code - 4'h1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign dout = state_q.out;
endmodule // osm_half_delay
`default_nettype wire

// file: rtl/osm_mesh_ctrl.sv
// Mesh, halftone and second colour control with APB register file.
`include "osm_regs.svh"
`default_nettype none
module osm_mesh_ctrl (
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // APB slave.
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   // Raster timing from the display generator.
   input  wire logic       dot_en,
   input  wire logic       hsync_pulse,
   input  wire logic       vsync_pulse,
   input  wire logic       row_start,
   input  wire logic [3:0] row_num,
   input  wire logic [4:0] char_col,
   input  wire logic       half_col,
   input  wire logic       field_odd,
   input  wire logic       isr_done,
   // Pixel inputs.
   input  wire logic       pix_fg,
   input  wire logic       pix_on,
   input  wire logic [2:0] fg_rgb,
   input  wire logic [2:0] bg_rgb,
   // Video outputs.
   output logic [2:0]      overlay_rgb,
   output logic            overlay_blank_output,
   output logic            halftone_output_pin,
   output logic            halftone_output_oe,
   // CPU interrupt.
   output logic            sync_irq_h,
   output logic            sync_irq_v,
   output logic            irq
);
   typedef struct packed {
      logic [7:0]          col_first;
      logic [7:0]          col_limit;
      logic [7:0]          row_ctrl;
      logic [7:0]          gen_ctrl;
      logic [7:0]          snd_pos;
      logic [7:0]          snd_ctrl;
      logic [1:0]          irq_stat;
      logic [1:0]          irq_mask;
      logic                row_mesh;
      osm_pkg::osm_svc_e   svc;
      logic                pend_h;
      logic                pend_v;
      logic                dot_phase;
      logic [2:0]          rgb;
      logic                blank_raw;
      logic                ht;
      logic                ht_dly;
      logic [31:0]         rdata;
   } osm_state_s;

   osm_state_s state_q;
   osm_state_s state_d;
   logic       blank_dly;
   logic [5:0] ridx;
   logic       algn;
   logic       acc;
   logic       wr;
   logic       in_win;
   logic       mesh_on;
   logic       parity;
   logic       show;
   logic       ht_act;
   logic [5:0] cur_half;

   // Half column number including the fixed screen offset.
   function automatic logic [5:0] half_pos(input logic [4:0] c,
                                           input logic h);
      half_pos = 6'({c, h}) + `OSM_SND_OFFSET;
   endfunction

   // Zero-wait APB slave: every access completes in its access phase.
   // Misaligned accesses still complete but touch no register.
   assign ridx    = paddr[7:2];
   assign algn    = paddr[1:0] == 2'b00;
   assign acc     = psel & penable & algn;
   assign wr      = acc & pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = state_q.rdata;

   // Window membership from the live column counter on every dot.
   assign in_win  = (char_col >= state_q.col_first[4:0]) &&
                    (char_col < state_q.col_limit[4:0]);
   assign mesh_on = state_q.gen_ctrl[`OSM_POS_MESH_EN] &
                    state_q.row_mesh & in_win &
                    ~state_q.gen_ctrl[`OSM_POS_HT_PIN];
   // Field parity is chosen by software or from the sync field flag.
   assign parity  = state_q.gen_ctrl[`OSM_POS_SW_MESH] ?
                    state_q.gen_ctrl[`OSM_POS_SW_FIELD] : field_odd;
   // Checkerboard by dot and row, flipped by the selected field parity; progressive gets no promise.
   assign show    = state_q.dot_phase ^ parity ^ row_num[0];
   assign ht_act  = state_q.gen_ctrl[`OSM_POS_HT_PIN] &
                    state_q.gen_ctrl[`OSM_POS_MESH_EN] &
                    state_q.row_mesh & in_win &
                    (~pix_fg | state_q.row_ctrl[`OSM_POS_FG_INC]);
   assign cur_half = half_pos(char_col, half_col);

   osm_half_delay #(
      .DEPTH (16)
   ) u_blank_dly (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .din     (state_q.blank_raw),
      .code    (state_q.row_ctrl[`OSM_POS_RDLY_HI:`OSM_POS_RDLY_LO]),
      .dout    (blank_dly)
   );

   // Next-state logic: registers, interrupt arbitration and pixel path.
   always_comb begin
      state_d = state_q;
      // Register writes.
      if (wr) begin
         unique case (ridx)
            `OSM_IDX_COL_FIRST: state_d.col_first = pwdata[7:0] & 8'h1f;
            `OSM_IDX_COL_LIMIT: state_d.col_limit = pwdata[7:0] & 8'h1f;
            `OSM_IDX_ROW_CTRL:
               state_d.row_ctrl = pwdata[7:0] & `OSM_ROW_WMASK;
            `OSM_IDX_GEN_CTRL:  state_d.gen_ctrl = pwdata[7:0];
            `OSM_IDX_SND_POS:   state_d.snd_pos = pwdata[7:0] & 8'h7f;
            `OSM_IDX_SND_CTRL:  state_d.snd_ctrl = pwdata[7:0];
            `OSM_IDX_IRQ_MASK:  state_d.irq_mask = pwdata[1:0];
            default: ;
         endcase
      end
      // Register reads, captured for the next cycle's data output.
      state_d.rdata = 32'h0;
      if (psel & ~penable & ~pwrite & algn) begin
         unique case (ridx)
            `OSM_IDX_COL_FIRST:
               state_d.rdata[7:0] = state_q.col_first | `OSM_RSV_COL;
            `OSM_IDX_COL_LIMIT:
               state_d.rdata[7:0] = state_q.col_limit | `OSM_RSV_COL;
            `OSM_IDX_ROW_CTRL:  state_d.rdata[7:0] = state_q.row_ctrl;
            `OSM_IDX_GEN_CTRL:  state_d.rdata[7:0] = state_q.gen_ctrl;
            `OSM_IDX_SND_POS:
               state_d.rdata[7:0] = state_q.snd_pos | `OSM_RSV_SND_POS;
            `OSM_IDX_SND_CTRL:  state_d.rdata[7:0] = state_q.snd_ctrl;
            `OSM_IDX_IRQ_STAT:  state_d.rdata[1:0] = state_q.irq_stat;
            `OSM_IDX_IRQ_MASK:  state_d.rdata[1:0] = state_q.irq_mask;
            `OSM_IDX_STATE:
               state_d.rdata[3:0] = {state_q.pend_v, state_q.pend_h,
                                     2'(state_q.svc)};
            default: state_d.rdata = 32'h0;
         endcase
      end
      // Per-row mesh bit is latched at the row start for the coming row.
      if (row_start) begin
         state_d.row_mesh = state_q.row_ctrl[`OSM_POS_ROW_MESH];
      end
      // Sync interrupt service and optional pending of the other source.
      unique case (state_q.svc)
         osm_pkg::OSM_IDLE: begin
            if (hsync_pulse | state_q.pend_h) begin
               state_d.svc    = osm_pkg::OSM_H_SVC;
               state_d.pend_h = 1'b0;
               state_d.pend_v = state_q.pend_v | vsync_pulse;
            end else if (vsync_pulse | state_q.pend_v) begin
               state_d.svc    = osm_pkg::OSM_V_SVC;
               state_d.pend_v = 1'b0;
            end
         end
         osm_pkg::OSM_H_SVC: begin
            if (vsync_pulse) begin
               state_d.pend_v = state_q.snd_pos[`OSM_POS_HOLD];
            end
            if (isr_done) begin
               state_d.svc = osm_pkg::OSM_IDLE;
            end
         end
         osm_pkg::OSM_V_SVC: begin
            if (hsync_pulse) begin
               state_d.pend_h = state_q.snd_pos[`OSM_POS_HOLD];
            end
            if (isr_done) begin
               state_d.svc = osm_pkg::OSM_IDLE;
            end
         end
         default: state_d.svc = osm_pkg::OSM_IDLE;
      endcase
      if (~state_q.snd_pos[`OSM_POS_HOLD]) begin
         state_d.pend_h = 1'b0;
         state_d.pend_v = 1'b0;
      end
      // Sticky status: a new event wins over a clear in the same cycle.
      if (wr && ridx == `OSM_IDX_IRQ_STAT) begin
         state_d.irq_stat = state_q.irq_stat & ~pwdata[1:0];
      end
      state_d.irq_stat = state_d.irq_stat | {vsync_pulse, hsync_pulse};
      // Pixel path, advanced once per dot.
      if (dot_en) begin
         state_d.dot_phase = ~state_q.dot_phase;
         state_d.rgb       = pix_fg ? fg_rgb : bg_rgb;
         state_d.blank_raw = pix_on;
         if (pix_fg && state_q.snd_ctrl[`OSM_POS_SC_EN] &&
             row_num == state_q.snd_ctrl[3:0] &&
             cur_half >= state_q.snd_pos[5:0]) begin
            state_d.rgb = state_q.snd_ctrl[6:4];
         end
         if (mesh_on && !pix_on) begin
            state_d.blank_raw = show;
            // Colour field is B,G,R high to low; output bus is R,G,B.
            state_d.rgb = {state_q.gen_ctrl[4], state_q.gen_ctrl[5],
                           state_q.gen_ctrl[6]};
         end
         // Halftone pin darkens live video; polarity from field bit.
         state_d.ht = ht_act ^ state_q.gen_ctrl[`OSM_POS_SW_FIELD];
         if (ht_act) begin
            state_d.blank_raw = pix_on & pix_fg;
         end
      end
      state_d.ht_dly = state_q.gen_ctrl[`OSM_POS_HT_DLY] ?
                       state_q.ht : state_d.ht;
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q          <= '0;
         state_q.svc      <= osm_pkg::OSM_IDLE;
         state_q.col_first <= `OSM_RST_COL;
         state_q.col_limit <= `OSM_RST_COL;
         state_q.row_ctrl <= `OSM_RST_ROW_CTRL;
         state_q.gen_ctrl <= `OSM_RST_GEN_CTRL;
         state_q.snd_pos  <= `OSM_RST_SND_POS;
         state_q.snd_ctrl <= `OSM_RST_SND_CTRL;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs; the pin is only driven while halftone mode owns it.
   assign overlay_rgb          = state_q.rgb;
   assign overlay_blank_output = blank_dly;
   assign halftone_output_pin  = state_q.ht_dly;
   assign halftone_output_oe   = state_q.gen_ctrl[`OSM_POS_HT_PIN];
   assign sync_irq_h = state_q.svc == osm_pkg::OSM_H_SVC;
   assign sync_irq_v = state_q.svc == osm_pkg::OSM_V_SVC;
   assign irq        = |(state_q.irq_stat & state_q.irq_mask);
endmodule // osm_mesh_ctrl
`default_nettype wire

// file: rtl/osm_pkg.sv
// Types shared by the mesh and second colour block.
`default_nettype none
package osm_pkg;
   typedef enum logic [1:0] {
      OSM_IDLE,
      OSM_H_SVC,
      OSM_V_SVC
   } osm_svc_e;
endpackage
`default_nettype wire

// file: rtl/osm_regs.svh
// Register offsets, field positions, reset values and the screen offset.
//==========================================================================
`ifndef OSM_REGS_SVH
`define OSM_REGS_SVH

//==========================================================================
// Register word indices; the byte address on the bus is four times these.
`define OSM_IDX_COL_FIRST   6'h04
`define OSM_IDX_COL_LIMIT   6'h05
`define OSM_IDX_ROW_CTRL    6'h06
`define OSM_IDX_GEN_CTRL    6'h07
`define OSM_IDX_SND_POS     6'h08
`define OSM_IDX_SND_CTRL    6'h09
`define OSM_IDX_IRQ_STAT    6'h0a
`define OSM_IDX_IRQ_MASK    6'h0b
`define OSM_IDX_STATE       6'h0c

//==========================================================================
// Field positions.
`define OSM_POS_HOLD        6
`define OSM_POS_RDLY_HI     7
`define OSM_POS_RDLY_LO     4
`define OSM_POS_FG_INC      3
`define OSM_POS_ROW_MESH    0
`define OSM_POS_HT_DLY      7
`define OSM_POS_CLR_HI      6
`define OSM_POS_CLR_LO      4
`define OSM_POS_HT_PIN      3
`define OSM_POS_SW_FIELD    2
`define OSM_POS_SW_MESH     1
`define OSM_POS_MESH_EN     0
`define OSM_POS_SC_EN       7

//==========================================================================
// Reset values and reserved read-back.
`define OSM_RST_COL         8'h00
`define OSM_RST_ROW_CTRL    8'h00
`define OSM_RST_GEN_CTRL    8'h00
`define OSM_RST_SND_POS     8'h00
`define OSM_RST_SND_CTRL    8'h00
`define OSM_RSV_COL         8'he0
`define OSM_RSV_SND_POS     8'h80
`define OSM_ROW_WMASK       8'hf9
`define OSM_SND_OFFSET      6'h03

`endif

// file: tb/osm_mesh_ctrl_monitor.sv
// Port checker for the mesh and second colour block.
`include "osm_regs.svh"
`default_nettype none
module osm_mesh_ctrl_monitor (
   // Clock and reset.
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Register bus.
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pin enable and service state.
   input wire logic        halftone_output_oe,
   input wire logic        sync_irq_h,
   input wire logic        sync_irq_v
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==============================================================
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic       acc;
   logic       rd;
   logic       wgen;
   logic [5:0] ridx;
   // Phases decoded once, so every property reads the same way.
   assign acc  = psel && penable;
   assign rd   = acc && !pwrite;
   assign ridx = paddr[7:2];
   assign wgen = acc && pwrite && paddr[1:0] == 2'b00 &&
                 ridx == `OSM_IDX_GEN_CTRL;
   chk_ready_high:
      assert property (acc |-> pready && !pslverr) else $error("stall");
   chk_rdata_idle:
      assert property (!acc |-> prdata == 32'h0) else $error("rdata");
   chk_first_rsv:
      assert property (rd && ridx == `OSM_IDX_COL_FIRST
         |-> prdata[31:5] == 27'h7) else $error("first high bits");
   chk_limit_rsv:
      assert property (rd && ridx == `OSM_IDX_COL_LIMIT
         |-> prdata[31:5] == 27'h7) else $error("limit high bits");
   chk_pos_rsv:
      assert property (rd && ridx == `OSM_IDX_SND_POS
         |-> prdata[31:7] == 25'h1) else $error("position bit 7");
   chk_row_rsv:
      assert property (rd && ridx == `OSM_IDX_ROW_CTRL
         |-> prdata[2:1] == 2'b00) else $error("row reserved");
   chk_pin_follow:
      assert property (wgen |=> halftone_output_oe == $past(pwdata[3]))
         else $error("pin select");
   chk_pin_hold:
      assert property (!wgen |=> $stable(halftone_output_oe))
         else $error("pin enable moved");
   chk_one_service:
      assert property (!(sync_irq_h && sync_irq_v)) else $error("two");
   // Main scenarios reached.
   cover property (wgen ##1 halftone_output_oe);
   cover property (sync_irq_h ##[1:20] sync_irq_v);
   cover property (rd && ridx == `OSM_IDX_IRQ_STAT && prdata[0]);
endmodule // osm_mesh_ctrl_monitor
`default_nettype wire

// file: tb/osm_mesh_ctrl_tb.sv
// Self-checking bench for the mesh and second colour block.
`include "osm_regs.svh"
`default_nettype none
module osm_mesh_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel, penable, pwrite, hsync_pulse, vsync_pulse;
   logic        dot_en = 1'b0;
   logic        row_start, half_col, field_odd, isr_done, pix_fg, pix_on;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  row_num;
   logic [4:0]  char_col;
   logic [2:0]  fg_rgb, bg_rgb, overlay_rgb;
   logic        pready, pslverr, overlay_blank_output, halftone_output_pin;
   logic        halftone_output_oe, sync_irq_h, sync_irq_v, irq;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          lat;
   // ==============================================================
   // Block and video receiver
   osm_mesh_ctrl DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dot_en(dot_en),
      .hsync_pulse(hsync_pulse), .vsync_pulse(vsync_pulse),
      .row_start(row_start), .row_num(row_num), .char_col(char_col),
      .half_col(half_col), .field_odd(field_odd), .isr_done(isr_done),
      .pix_fg(pix_fg), .pix_on(pix_on), .fg_rgb(fg_rgb), .bg_rgb(bg_rgb),
      .overlay_rgb(overlay_rgb), .overlay_blank_output(overlay_blank_output),
      .halftone_output_pin(halftone_output_pin),
      .halftone_output_oe(halftone_output_oe), .sync_irq_h(sync_irq_h),
      .sync_irq_v(sync_irq_v), .irq(irq));
   osm_video_sink u_sink (.clk_sys(clk_sys), .mark(pix_on),
      .overlay_blank_output(overlay_blank_output), .blank_lat(lat));
   // Clock, dot strobe at half the clock rate, and a hang guard.
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) dot_en <= ~dot_en;
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      end_of_test();
   end
   task automatic end_of_test();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         n_errors++;
      end
   endtask
   // One transfer; the request holds until pready is seen at an edge.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {a[5:0], 2'b00}; // Word index to byte address.
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      check("prdata", e, q);
   endtask
   // Four consecutive blanking samples, one mesh period of two dots each.
   task automatic samp(output logic [3:0] v);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         v[i] = overlay_blank_output;
      end
   endtask
   // Pulses {isr_done, vsync, hsync} for one cycle, then lets it settle.
   task automatic ev(input logic [2:0] k);
      {isr_done, vsync_pulse, hsync_pulse} <= k;
      @(posedge clk_sys);
      {isr_done, vsync_pulse, hsync_pulse} <= 3'h0;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic t_regs();
      rd(`OSM_IDX_COL_FIRST, 32'he0);
      rd(`OSM_IDX_SND_POS, 32'h80);
      rd(`OSM_IDX_GEN_CTRL, 32'h00);
      wr(`OSM_IDX_COL_LIMIT, 32'h15);
      rd(`OSM_IDX_COL_LIMIT, 32'hf5);
      wr(`OSM_IDX_ROW_CTRL, 32'hff);
      rd(`OSM_IDX_ROW_CTRL, 32'hf9);
      wr(`OSM_IDX_GEN_CTRL, 32'h08);
      check("oe", 32'h1, halftone_output_oe);
      wr(`OSM_IDX_GEN_CTRL, 32'h00);
      check("oe", 32'h0, halftone_output_oe);
      wr(8'h10, 32'hff);
      rd(8'h10, 32'h0);
   endtask
   task automatic t_irq();
      wr(`OSM_IDX_IRQ_MASK, 32'h0);
      ev(3'b001);
      rd(`OSM_IDX_IRQ_STAT, 32'h1);
      check("irq", 32'h0, irq);
      wr(`OSM_IDX_IRQ_MASK, 32'h1);
      check("irq", 32'h1, irq);
      wr(`OSM_IDX_IRQ_STAT, 32'h1);
      check("irq", 32'h0, irq);
      ev(3'b100);
      ev(3'b010);
      rd(`OSM_IDX_IRQ_STAT, 32'h2);
      wr(`OSM_IDX_IRQ_STAT, 32'h2);
      ev(3'b100);
   endtask
   task automatic t_pend();
      wr(`OSM_IDX_SND_POS, 32'h40);
      ev(3'b001);
      check("svc_h", 32'h1, sync_irq_h);
      ev(3'b010);
      ev(3'b100);
      check("svc_v", 32'h1, sync_irq_v);
      ev(3'b100);
      wr(`OSM_IDX_SND_POS, 32'h00);
      ev(3'b001);
      ev(3'b010);
      ev(3'b100);
      check("svc_v", 32'h0, sync_irq_v);
      check("svc_h", 32'h0, sync_irq_h);
   endtask
   task automatic t_second();
      wr(`OSM_IDX_SND_POS, 32'h09);
      wr(`OSM_IDX_SND_CTRL, 32'hd4);
      row_num <= 4'h4;
      {pix_on, pix_fg, half_col} <= 3'b111;
      fg_rgb <= 3'b010;
      char_col <= 5'd2;
      repeat (6) @(posedge clk_sys);
      check("rgb", 32'h2, overlay_rgb);
      char_col <= 5'd3;
      half_col <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check("rgb", 32'h5, overlay_rgb);
      row_num <= 4'h5;
      repeat (6) @(posedge clk_sys);
      check("rgb", 32'h2, overlay_rgb);
      pix_on <= 1'b0;
   endtask
   // Mesh over columns 2 to 4, then halftone on the pin.
   task automatic t_mesh();
      logic [3:0] p, q;
      {pix_fg, char_col, row_num, bg_rgb} <= {1'b0, 5'd0, 4'h0, 3'h3};
      wr(`OSM_IDX_COL_FIRST, 32'h02);
      wr(`OSM_IDX_COL_LIMIT, 32'h05);
      wr(`OSM_IDX_ROW_CTRL, 32'h01);
      wr(`OSM_IDX_GEN_CTRL, 32'h11);
      char_col <= 5'd4;
      repeat (6) @(posedge clk_sys);
      check("rgb", 32'h3, overlay_rgb);
      row_start <= 1'b1;
      @(posedge clk_sys);
      row_start <= 1'b0;
      repeat (6) @(posedge clk_sys);
      check("rgb", 32'h4, overlay_rgb);
      char_col <= 5'd5;
      repeat (6) @(posedge clk_sys);
      check("rgb", 32'h3, overlay_rgb);
      char_col <= 5'd3;
      repeat (6) @(posedge clk_sys);
      samp(p);
      check("mesh_ones", 32'h2, $countones(p));
      field_odd <= ~field_odd;
      repeat (4) @(posedge clk_sys);
      samp(q);
      check("hw_field", {28'h0, ~p}, q);
      wr(`OSM_IDX_GEN_CTRL, 32'h13);
      repeat (4) @(posedge clk_sys);
      samp(p);
      field_odd <= ~field_odd;
      repeat (4) @(posedge clk_sys);
      samp(q);
      check("sw_field", {28'h0, p}, q);
      wr(`OSM_IDX_GEN_CTRL, 32'h19);
      repeat (4) @(posedge clk_sys);
      check("ht_pin", 32'h1, halftone_output_pin);
      check("ht_oe", 32'h1, halftone_output_oe);
      pix_fg <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("ht_fg", 32'h0, halftone_output_pin);
      wr(`OSM_IDX_ROW_CTRL, 32'h09);
      repeat (4) @(posedge clk_sys);
      check("ht_fg", 32'h1, halftone_output_pin);
      wr(`OSM_IDX_GEN_CTRL, 32'h1d);
      repeat (4) @(posedge clk_sys);
      check("ht_pol", 32'h0, halftone_output_pin);
      char_col <= 5'd0;
      repeat (4) @(posedge clk_sys);
      wr(`OSM_IDX_GEN_CTRL, 32'h00);
   endtask
   // Each code adds one clock, half a dot, over the code zero latency.
   task automatic t_delay();
      int base;
      for (int c = 0; c < 16; c++) begin
         wr(`OSM_IDX_ROW_CTRL, {24'h0, c[3:0], 4'h0});
         while (dot_en !== 1'b1) @(posedge clk_sys);
         pix_on <= 1'b1;
         repeat (30) @(posedge clk_sys);
         if (c == 0) base = lat;
         check("blank_lat", base + c, lat);
         pix_on <= 1'b0;
         // Long enough to flush the sixteen taps before the next code.
         repeat (20) @(posedge clk_sys);
      end
   endtask
   // Main sequence.
   initial begin
      {psel, penable, pwrite, hsync_pulse, vsync_pulse} = '0;
      {row_start, half_col, field_odd, isr_done, pix_fg, pix_on} = '0;
      {paddr, pwdata, row_num, char_col, fg_rgb, bg_rgb} = '0;
      repeat (16) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_regs();
      t_irq();
      t_pend();
      t_second();
      t_mesh();
      t_delay();
      end_of_test();
   end
endmodule // osm_mesh_ctrl_tb
bind osm_mesh_ctrl osm_mesh_ctrl_monitor u_mon (.clk_sys(clk_sys),
   .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .halftone_output_oe(halftone_output_oe),
   .sync_irq_h(sync_irq_h), .sync_irq_v(sync_irq_v));
`default_nettype wire

// file: tb/osm_video_sink.sv
// Video receiver model that times the blanking edge.
`default_nettype none
module osm_video_sink (
   // Clock.
   input wire logic clk_sys,
   // Overlay blanking and bench start marker.
   input wire logic overlay_blank_output,
   input wire logic mark,
   // Cycles from marker to blanking, -1 if none.
   output var int   blank_lat
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;
   // Only the first blanking edge is kept, so later video cannot move it.
   always @(posedge clk_sys) begin
      if (!mark) begin
         cnt <= 0;
         blank_lat <= -1;
      end else if (overlay_blank_output && blank_lat < 0) begin
         blank_lat <= cnt;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // osm_video_sink
`default_nettype wire
